// *** common/fpb_pkg.sv ***
// shared constants and types for the faceplate key and display logic
package fpb_pkg;
  // ****************************************
  // clock and time base
  // ****************************************
  localparam int CLK_HZ = 100000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int TICK_CNT_W = 20;
  // ****************************************
  // key counts and key index map
  // ****************************************
  localparam int N_CKEY = 7;
  localparam int N_STD_CKEY = 3;
  localparam int N_UBTN = 12;
  localparam int UBTN_BASE = N_CKEY;
  localparam int DOWN_KEY = N_CKEY + N_UBTN;
  localparam int MENU_KEY = DOWN_KEY + 1;
  localparam int N_KEY = MENU_KEY + 1;
  localparam int N_DISP = 16;
  // ****************************************
  // packed state register map
  // ****************************************
  localparam int FLEX_BITS = 256;
  localparam int FLEX_W = 16;
  localparam int FLEX_WORDS = FLEX_BITS / FLEX_W;
  localparam logic [15:0] FLEX_BASE = 16'h0900;
  // ****************************************
  // millisecond timings
  // ****************************************
  localparam int CK_STRETCH_MS = 100;
  localparam int STEP_MIN_MS = 250;
  localparam int CYCLE_S = 4;
  localparam logic [6:0] CK_STRETCH_TICKS = 7'(CK_STRETCH_MS);
  localparam logic [7:0] STEP_MIN_TICKS = 8'(STEP_MIN_MS);
  localparam logic [11:0] CYCLE_TICKS = 12'(CYCLE_S * MS_PER_S);
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    BTN_DISABLED, BTN_SELF_RESET, BTN_LATCHED
  } fpb_btn_mode_t;
  typedef enum logic [1:0] {
    DS_IDLE, DS_KEYPAD, DS_STEP, DS_CYCLE
  } fpb_disp_t;
  typedef struct packed {
    logic show;
    logic [3:0] btn;
    logic off_line;
  } fpb_msg_t;
  typedef struct packed {
    logic valid;
    logic [2:0] key;
  } fpb_event_t;
  typedef struct packed {
    logic active;
    logic cycling;
    logic [3:0] idx;
  } fpb_disp_out_t;
  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } fpb_rd_req_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] data;
  } fpb_rd_rsp_t;
endpackage

// *** rtl/fpb_ms_tick.sv ***
// millisecond tick divider
`timescale 1ns/10ps
`default_nettype none
module fpb_ms_tick #(
  parameter int TICK_CYCLES = fpb_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // tick
  output logic tick_out
);
  typedef struct packed {
    logic [fpb_pkg::TICK_CNT_W-1:0] cnt;
    logic tick;
  } fpb_tick_st_t;

  localparam logic [fpb_pkg::TICK_CNT_W-1:0] LAST =
    fpb_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

  fpb_tick_st_t s_r;
  fpb_tick_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = (s_r.cnt == LAST);
    if (s_r.cnt == LAST)
    begin
      s_nxt.cnt = '0;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign tick_out = s_r.tick;
endmodule
`default_nettype wire

// *** rtl/fpb_user_button.sv ***
// one user button: disabled, self-reset with drop-out, or latched
`timescale 1ns/10ps
`default_nettype none
module fpb_user_button (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ms_tick_in,
  // key and settings
  input wire logic level_in,
  input wire logic press_in,
  input wire fpb_pkg::fpb_btn_mode_t mode_in,
  input wire logic [15:0] drop_ms_in,
  // stored state restore
  input wire logic load_in,
  input wire logic load_val_in,
  // operands
  output logic on_out,
  output logic off_out
);
  typedef struct packed {
    logic latch;
    logic [15:0] stretch;
    logic on;
    logic off;
  } fpb_btn_st_t;

  fpb_btn_st_t s_r;
  fpb_btn_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    unique case (mode_in)
      fpb_pkg::BTN_SELF_RESET:
      begin
        if (level_in)
        begin
          s_nxt.stretch = drop_ms_in;
        end
        else if (ms_tick_in && s_r.stretch != 16'h0000)
        begin
          s_nxt.stretch = s_r.stretch - 16'h0001;
        end
        s_nxt.on = level_in || (s_r.stretch != 16'h0000);
        s_nxt.off = !s_nxt.on;
      end
      fpb_pkg::BTN_LATCHED:
      begin
        s_nxt.stretch = '0;
        if (press_in)
        begin
          s_nxt.latch = !s_r.latch;
        end
        s_nxt.on = s_nxt.latch;
        s_nxt.off = !s_nxt.latch;
      end
      default:
      begin
        s_nxt.stretch = '0;
        s_nxt.on = 1'b0;
        s_nxt.off = 1'b0;
      end
    endcase
    if (load_in)
    begin
      s_nxt.latch = load_val_in;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign on_out = s_r.on;
  assign off_out = s_r.off;
endmodule
`default_nettype wire

// *** rtl/fpb_faceplate.sv ***
// faceplate keys, user buttons, packed states and user displays
// How it works
// - control key operand held 100 ms after release
// - three keys, four more with option
// - breaker mode routes standard keys to breaker
// - key press logs event when enabled
// - one key at a time; others ignored
// - each user button has on/off operands
// - disabled button holds both operands low
// - self-reset: on while held, off complement
// - latched: each press toggles on/off
// - latched state saved and restored after power
// - indicator mirrors button on operand
// - self-reset drop-out time stretches on operand
// - title/on line; off line only latched
// - 256 states packed 16 per word
// - sixteen words read from address 900 hex
// - up to 16 displays, programmed only
// - step first reopens last, then advances
// - step input and down key both advance
// - timeout starts cycling; step stops it
// - step pulse must last 250 ms
// - keypad view leaves after timeout
// - cycling advances every 4 seconds
`timescale 1ns/10ps
`default_nettype none
module fpb_faceplate #(
  parameter int MS_TICK_CYCLES = fpb_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // faceplate key pins
  input wire logic [fpb_pkg::N_CKEY-1:0] control_key_in,
  input wire logic [fpb_pkg::N_UBTN-1:0] user_button_in,
  input wire logic down_key_in,
  input wire logic menu_key_in,
  // settings
  input wire logic option_fitted_in,
  input wire logic breaker_keys_in,
  input wire logic [fpb_pkg::N_CKEY-1:0] key_log_en_in,
  input wire fpb_pkg::fpb_btn_mode_t [fpb_pkg::N_UBTN-1:0] btn_mode_in,
  input wire logic [fpb_pkg::N_UBTN-1:0][15:0] release_stretch_time_in,
  input wire logic [fpb_pkg::N_DISP-1:0] display_programmed_in,
  input wire logic [15:0] msg_timeout_ms_in,
  // stored latched states
  input wire logic [fpb_pkg::N_UBTN-1:0] nv_state_in,
  // internal operands
  input wire logic display_step_input_in,
  input wire logic [fpb_pkg::FLEX_BITS-1:0] flex_state_in,
  // register read port
  input wire fpb_pkg::fpb_rd_req_t rd_req_in,
  output fpb_pkg::fpb_rd_rsp_t rd_rsp_out,
  // control key outputs
  output logic [fpb_pkg::N_CKEY-1:0] control_key_active_out,
  output logic [fpb_pkg::N_STD_CKEY-1:0] breaker_cmd_out,
  output fpb_pkg::fpb_event_t event_out,
  // user button outputs
  output logic [fpb_pkg::N_UBTN-1:0] button_on_out,
  output logic [fpb_pkg::N_UBTN-1:0] button_off_out,
  output logic [fpb_pkg::N_UBTN-1:0] button_led_out,
  output logic [fpb_pkg::N_UBTN-1:0] nv_state_out,
  output fpb_pkg::fpb_msg_t msg_out,
  // user display outputs
  output fpb_pkg::fpb_disp_out_t disp_out
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [fpb_pkg::N_KEY-1:0] meta;
    logic [fpb_pkg::N_KEY-1:0] sync;
    logic [fpb_pkg::N_KEY-1:0] prev;
    logic [4:0] owner;
    logic [fpb_pkg::N_CKEY-1:0][6:0] ck_cnt;
    logic [fpb_pkg::N_CKEY-1:0] ck_act;
    logic [fpb_pkg::N_STD_CKEY-1:0] brk;
    fpb_pkg::fpb_event_t evt;
    logic loaded;
    logic [fpb_pkg::N_UBTN-1:0] on_prev;
    logic [fpb_pkg::N_UBTN-1:0] nv;
    fpb_pkg::fpb_msg_t msg;
    fpb_pkg::fpb_disp_t dmode;
    logic [3:0] idx;
    logic [3:0] last;
    logic [15:0] idle_ms;
    logic [11:0] cyc_ms;
    logic [7:0] step_ms;
    logic step_done;
    fpb_pkg::fpb_disp_out_t dout;
    fpb_pkg::fpb_rd_rsp_t rsp;
  } fpb_main_st_t;

  fpb_main_st_t s_r;
  fpb_main_st_t s_nxt;
  logic ms_tick;
  logic [fpb_pkg::N_UBTN-1:0] btn_on;
  logic [fpb_pkg::N_UBTN-1:0] btn_off;
  logic [fpb_pkg::N_KEY-1:0] held;
  logic [fpb_pkg::N_KEY-1:0] press;

  // next programmed display after i, wrapping
  function automatic logic [3:0] next_prog(
    input logic [3:0] i,
    input logic [fpb_pkg::N_DISP-1:0] m
  );
    logic [3:0] r;
    logic hit;
    r = i;
    hit = 1'b0;
    for (int k = 1; k <= fpb_pkg::N_DISP; k++)
    begin
      if (!hit && m[4'(i + 4'(k))])
      begin
        r = 4'(i + 4'(k));
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // ****************************************
  // millisecond tick
  // ****************************************
  // ms time base
  fpb_ms_tick #(
    .TICK_CYCLES(MS_TICK_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_out(ms_tick)
  );

  // ****************************************
  // key lockout
  // ****************************************
  always_comb
  begin
    held = '0;
    press = '0;
    for (int k = 0; k < fpb_pkg::N_KEY; k++)
    begin
      held[k] = s_r.sync[k] && (s_r.owner == 5'(k + 1));
    end
    if (s_r.owner == 5'h00)
    begin
      for (int k = fpb_pkg::N_KEY - 1; k >= 0; k--)
      begin
        if (s_r.sync[k] && !s_r.prev[k])
        begin
          press = '0;
          press[k] = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // user buttons
  // ****************************************
  generate
    for (genvar j = 0; j < fpb_pkg::N_UBTN; j++)
    begin : g_btn
      fpb_user_button u_btn (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ms_tick_in(ms_tick),
        .level_in(held[fpb_pkg::UBTN_BASE + j]),
        .press_in(press[fpb_pkg::UBTN_BASE + j]),
        .mode_in(btn_mode_in[j]),
        .drop_ms_in(release_stretch_time_in[j]),
        .load_in(!s_r.loaded),
        .load_val_in(nv_state_in[j]),
        .on_out(btn_on[j]),
        .off_out(btn_off[j])
      );
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic step_fire;
    logic act;
    logic any_prog;
    logic ck_en;
    logic brk_key;
    s_nxt = s_r;
    step_fire = 1'b0;
    act = 1'b0;
    ck_en = 1'b0;
    brk_key = 1'b0;
    any_prog = |display_programmed_in;
    s_nxt.meta = {menu_key_in, down_key_in, user_button_in,
                  control_key_in};
    s_nxt.sync = s_r.meta;
    s_nxt.prev = s_r.sync;
    s_nxt.loaded = 1'b1;

    if (s_r.owner != 5'h00 && !held[5'(s_r.owner - 5'h01)])
    begin
      s_nxt.owner = 5'h00;
    end
    for (int k = 0; k < fpb_pkg::N_KEY; k++)
    begin
      if (press[k])
      begin
        s_nxt.owner = 5'(k + 1);
      end
    end

    // control keys
    s_nxt.evt = '0;
    for (int k = 0; k < fpb_pkg::N_CKEY; k++)
    begin
      ck_en = (k < fpb_pkg::N_STD_CKEY) || option_fitted_in;
      brk_key = breaker_keys_in && (k < fpb_pkg::N_STD_CKEY);
      if (held[k] && ck_en && !brk_key)
      begin
        s_nxt.ck_cnt[k] = fpb_pkg::CK_STRETCH_TICKS;
      end
      else if (ms_tick && s_r.ck_cnt[k] != 7'h00)
      begin
        s_nxt.ck_cnt[k] = s_r.ck_cnt[k] - 7'h01;
      end
      if (!ck_en || brk_key)
      begin
        s_nxt.ck_cnt[k] = 7'h00;
      end
      s_nxt.ck_act[k] = (held[k] && ck_en && !brk_key)
                        || (s_nxt.ck_cnt[k] != 7'h00);
      if (press[k] && ck_en && !brk_key && key_log_en_in[k])
      begin
        s_nxt.evt.valid = 1'b1;
        s_nxt.evt.key = 3'(k);
      end
    end
    for (int k = 0; k < fpb_pkg::N_STD_CKEY; k++)
    begin
      s_nxt.brk[k] = held[k] && breaker_keys_in;
    end

    // button messages and stored state
    s_nxt.on_prev = btn_on;
    for (int j = 0; j < fpb_pkg::N_UBTN; j++)
    begin
      // on line at on, off line latched only
      if (btn_on[j] && !s_r.on_prev[j])
      begin
        s_nxt.msg = '{show: 1'b1, btn: 4'(j), off_line: 1'b0};
      end
      else if (!btn_on[j] && s_r.on_prev[j])
      begin
        if (btn_mode_in[j] == fpb_pkg::BTN_LATCHED)
        begin
          s_nxt.msg = '{show: 1'b1, btn: 4'(j), off_line: 1'b1};
        end
        else if (s_r.msg.btn == 4'(j))
        begin
          s_nxt.msg.show = 1'b0;
        end
      end
      if (s_r.loaded && btn_mode_in[j] == fpb_pkg::BTN_LATCHED)
      begin
        s_nxt.nv[j] = btn_on[j];
      end
      else if (!s_r.loaded)
      begin
        s_nxt.nv[j] = nv_state_in[j];
      end
    end

    if (!display_step_input_in)
    begin
      s_nxt.step_ms = 8'h00;
      s_nxt.step_done = 1'b0;
    end
    else
    begin
      if (ms_tick && s_r.step_ms != fpb_pkg::STEP_MIN_TICKS)
      begin
        s_nxt.step_ms = s_r.step_ms + 8'h01;
      end
      if (s_r.step_ms == fpb_pkg::STEP_MIN_TICKS && !s_r.step_done)
      begin
        step_fire = 1'b1;
        s_nxt.step_done = 1'b1;
      end
    end

    act = step_fire || press[fpb_pkg::DOWN_KEY]
          || press[fpb_pkg::MENU_KEY];
    if (act)
    begin
      s_nxt.idle_ms = 16'h0000;
    end
    else if (ms_tick && s_r.idle_ms != 16'hFFFF)
    begin
      s_nxt.idle_ms = s_r.idle_ms + 16'h0001;
    end

    // user display sequence
    unique case (s_r.dmode)
      fpb_pkg::DS_IDLE:
      begin
        if (press[fpb_pkg::MENU_KEY] && any_prog)
        begin
          s_nxt.dmode = fpb_pkg::DS_KEYPAD;
          s_nxt.idx = next_prog(4'hF, display_programmed_in);
        end
        else if (step_fire && any_prog)
        begin
          s_nxt.dmode = fpb_pkg::DS_STEP;
          s_nxt.idx = display_programmed_in[s_r.last] ? s_r.last
                      : next_prog(s_r.last, display_programmed_in);
        end
        else if (!act && any_prog
                 && s_r.idle_ms >= msg_timeout_ms_in)
        begin
          s_nxt.dmode = fpb_pkg::DS_CYCLE;
          s_nxt.cyc_ms = 12'h000;
          s_nxt.idx = display_programmed_in[s_r.last] ? s_r.last
                      : next_prog(s_r.last, display_programmed_in);
        end
      end
      fpb_pkg::DS_KEYPAD, fpb_pkg::DS_STEP:
      begin
        if (press[fpb_pkg::MENU_KEY])
        begin
          s_nxt.dmode = fpb_pkg::DS_IDLE;
        end
        else if (step_fire || press[fpb_pkg::DOWN_KEY])
        begin
          s_nxt.idx = next_prog(s_r.idx, display_programmed_in);
        end
        else if (s_r.idle_ms >= msg_timeout_ms_in
                 && s_r.dmode == fpb_pkg::DS_KEYPAD)
        begin
          s_nxt.dmode = fpb_pkg::DS_IDLE;
        end
        else if (s_r.idle_ms >= msg_timeout_ms_in)
        begin
          s_nxt.dmode = fpb_pkg::DS_CYCLE;
          s_nxt.cyc_ms = 12'h000;
        end
      end
      fpb_pkg::DS_CYCLE:
      begin
        if (press[fpb_pkg::MENU_KEY])
        begin
          s_nxt.dmode = fpb_pkg::DS_IDLE;
        end
        else if (step_fire)
        begin
          s_nxt.dmode = fpb_pkg::DS_STEP;
        end
        else if (press[fpb_pkg::DOWN_KEY])
        begin
          s_nxt.dmode = fpb_pkg::DS_STEP;
          s_nxt.idx = next_prog(s_r.idx, display_programmed_in);
        end
        else if (ms_tick)
        begin
          if (s_r.cyc_ms == fpb_pkg::CYCLE_TICKS - 12'h001)
          begin
            s_nxt.cyc_ms = 12'h000;
            s_nxt.idx = next_prog(s_r.idx, display_programmed_in);
          end
          else
          begin
            s_nxt.cyc_ms = s_r.cyc_ms + 12'h001;
          end
        end
      end
    endcase
    if (s_nxt.dmode != fpb_pkg::DS_IDLE)
    begin
      s_nxt.last = s_nxt.idx;
    end
    s_nxt.dout.active = (s_nxt.dmode != fpb_pkg::DS_IDLE);
    s_nxt.dout.cycling = (s_nxt.dmode == fpb_pkg::DS_CYCLE);
    s_nxt.dout.idx = s_nxt.idx;

    s_nxt.rsp = '0;
    if (rd_req_in.rd)
    begin
      s_nxt.rsp.ack = 1'b1;
      if (rd_req_in.addr[15:4] == fpb_pkg::FLEX_BASE[15:4])
      begin
        s_nxt.rsp.data =
          flex_state_in[{rd_req_in.addr[3:0], 4'h0} +: fpb_pkg::FLEX_W];
      end
      else
      begin
        s_nxt.rsp.err = 1'b1;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // reset clears all timers
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rd_rsp_out = s_r.rsp;
  assign control_key_active_out = s_r.ck_act;
  assign breaker_cmd_out = s_r.brk;
  assign event_out = s_r.evt;
  assign button_on_out = btn_on;
  assign button_off_out = btn_off;
  assign button_led_out = btn_on;
  assign nv_state_out = s_r.nv;
  assign msg_out = s_r.msg;
  assign disp_out = s_r.dout;
endmodule
`default_nettype wire

// *** dv/fpb_operator.sv ***
// operator model pressing one faceplate key at a time
`timescale 1ns/10ps
`default_nettype none
module fpb_operator (
  // clock
  input wire logic clk_in,
  // command from the bench
  input wire logic [4:0] key_sel_in,
  input wire logic hold_in,
  // faceplate pins, 0..6 control, 7..18 user, 19 down, 20 menu
  output logic [20:0] pins_out
);
  always @(posedge clk_in)
  begin
    pins_out <= hold_in ? 21'h000001 << key_sel_in : 21'h000000;
  end
endmodule
`default_nettype wire

// *** dv/fpb_checker.sv ***
// assertion checker for the faceplate block
`timescale 1ns/10ps
`default_nettype none
module fpb_checker #(
  parameter int MS_TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // watched inputs
  input wire logic [6:0] control_key_in,
  input wire logic [6:0] key_log_en_in,
  input wire fpb_pkg::fpb_btn_mode_t [11:0] btn_mode_in,
  input wire logic [255:0] flex_state_in,
  input wire fpb_pkg::fpb_rd_req_t rd_req_in,
  // watched outputs
  input wire fpb_pkg::fpb_rd_rsp_t rd_rsp_out,
  input wire logic [6:0] control_key_active_out,
  input wire fpb_pkg::fpb_event_t event_out,
  input wire logic [11:0] button_on_out,
  input wire logic [11:0] button_off_out,
  input wire logic [11:0] button_led_out
);
  localparam int LO = 99 * MS_TICK_CYCLES;
  localparam int HI = 102 * MS_TICK_CYCLES + 8;
  logic [2:0] up_r;
  logic [15:0] low_r;
  logic [15:0] word_r;
  logic [11:0] dis_m;
  logic [11:0] sr_m;
  logic inr;
  assign inr = rd_req_in.addr[15:4] == 12'h090;
  always_comb
  begin
    for (int i = 0; i < 12; i++)
    begin
      sr_m[i] = btn_mode_in[i] == fpb_pkg::BTN_SELF_RESET;
      dis_m[i] = !sr_m[i] && btn_mode_in[i] != fpb_pkg::BTN_LATCHED;
    end
  end
  // settle count, key 0 low time, word at request
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      up_r <= 3'h0;
      low_r <= 16'h0000;
      word_r <= 16'h0000;
    end
    else
    begin
      up_r <= up_r + 3'(up_r != 3'h7);
      low_r <= control_key_in[0] ? 16'h0000 : low_r + 16'(low_r != 16'hFFFF);
      word_r <= flex_state_in[16 * rd_req_in.addr[3:0] +: 16];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence rd_ok_s;
    rd_req_in.rd && inr;
  endsequence
  sequence rd_bad_s;
    rd_req_in.rd && !inr;
  endsequence
  read_ack_a: assert property (rd_req_in.rd |=> rd_rsp_out.ack)
    else $error("no ack after read");
  ack_cause_a: assert property (rd_rsp_out.ack |-> $past(rd_req_in.rd))
    else $error("ack without read");
  read_word_a: assert property (rd_ok_s |=> !rd_rsp_out.err
    && rd_rsp_out.data == word_r) else $error("wrong packed word");
  read_err_a: assert property (rd_bad_s |=> rd_rsp_out.err
    && rd_rsp_out.data == 16'h0000) else $error("bad address accepted");
  led_mirror_a: assert property (button_led_out == button_on_out)
    else $error("indicator differs");
  disabled_low_a: assert property (up_r == 3'h7 |->
    ((button_on_out | button_off_out) & dis_m) == 12'h000)
    else $error("disabled button drives");
  self_reset_a: assert property (up_r == 3'h7 |->
    ((button_on_out ^ button_off_out) & sr_m) == sr_m)
    else $error("off not complement");
  event_cause_a: assert property (event_out.valid |->
    key_log_en_in[event_out.key] ##1
    control_key_active_out[$past(event_out.key)])
    else $error("event without enabled press");
  event_pulse_a: assert property (event_out.valid |=> !event_out.valid)
    else $error("event longer than a cycle");
  key_stretch_a: assert property ($fell(control_key_active_out[0]) |->
    low_r inside {[LO:HI]}) else $error("release stretch wrong");
endmodule
bind fpb_faceplate fpb_checker #(
  .MS_TICK_CYCLES(MS_TICK_CYCLES)
) fpb_checker_i (
  .clk_in,
  .reset_in,
  .control_key_in,
  .key_log_en_in,
  .btn_mode_in,
  .flex_state_in,
  .rd_req_in,
  .rd_rsp_out,
  .control_key_active_out,
  .event_out,
  .button_on_out,
  .button_off_out,
  .button_led_out
);
`default_nettype wire

// *** dv/fpb_faceplate_test.sv ***
// self-checking testbench for the faceplate block
`timescale 1ns/10ps
`default_nettype none
module fpb_faceplate_test;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic hold = 1'b0;
  logic [4:0] key_sel = 5'h00;
  logic [20:0] pins;
  logic option_fitted_in = 1'b0;
  logic breaker_keys_in = 1'b0;
  logic [6:0] key_log_en_in = 7'h7B;
  fpb_pkg::fpb_btn_mode_t [11:0] btn_mode_in;
  logic [11:0][15:0] release_stretch_time_in;
  logic [15:0] display_programmed_in = 16'h0025;
  logic [15:0] msg_timeout_ms_in = 16'hFFFF;
  logic [11:0] nv_state_in = 12'h004;
  logic display_step_input_in = 1'b0;
  logic [255:0] flex_state_in;
  fpb_pkg::fpb_rd_req_t rd_req_in = '0;
  fpb_pkg::fpb_rd_rsp_t rd_rsp_out;
  logic [6:0] control_key_active_out;
  logic [2:0] breaker_cmd_out;
  fpb_pkg::fpb_event_t event_out;
  logic [11:0] button_on_out;
  logic [11:0] button_off_out;
  logic [11:0] button_led_out;
  logic [11:0] nv_state_out;
  fpb_pkg::fpb_msg_t msg_out;
  fpb_pkg::fpb_disp_out_t disp_out;
  int n_fail = 0;
  int comparisons = 0;
  int nev;
  logic [2:0] evk;
  logic br;
  logic [3:0] i0;
  initial forever #5 clk_in = ~clk_in;
  fpb_operator fpb_operator_i (
    .clk_in,
    .key_sel_in(key_sel),
    .hold_in(hold),
    .pins_out(pins)
  );
  fpb_faceplate #(
    .MS_TICK_CYCLES(10)
  ) fpb_faceplate_i (
    .clk_in,
    .reset_in,
    .control_key_in(pins[6:0]),
    .user_button_in(pins[18:7]),
    .down_key_in(pins[19]),
    .menu_key_in(pins[20]),
    .option_fitted_in,
    .breaker_keys_in,
    .key_log_en_in,
    .btn_mode_in,
    .release_stretch_time_in,
    .display_programmed_in,
    .msg_timeout_ms_in,
    .nv_state_in,
    .display_step_input_in,
    .flex_state_in,
    .rd_req_in,
    .rd_rsp_out,
    .control_key_active_out,
    .breaker_cmd_out,
    .event_out,
    .button_on_out,
    .button_off_out,
    .button_led_out,
    .nv_state_out,
    .msg_out,
    .disp_out
  );
  // ****************************************
  // access tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] d, input logic e);
    rd_req_in = {1'b1, a};
    tick(1);
    rd_req_in = '0;
    check(16'(rd_rsp_out[17:16]), {14'h0000, 1'b1, e});
    check(rd_rsp_out.data, d);
    tick(1);
  endtask
  // hold a key n cycles, collecting events and breaker command
  task automatic press(input logic [4:0] k, input int n);
    key_sel = k;
    hold = 1'b1;
    nev = 0;
    br = 1'b0;
    for (int c = 0; c < n + 10; c++)
    begin
      if (c == n)
        hold = 1'b0;
      tick(1);
      if (event_out.valid === 1'b1)
      begin
        nev++;
        evk = event_out.key;
      end
      br |= breaker_cmd_out[1];
    end
  endtask
  task automatic step(input int n);
    display_step_input_in = 1'b1;
    tick(n);
    display_step_input_in = 1'b0;
    tick(20);
  endtask
  function automatic logic [3:0] nxt(input logic [3:0] c);
    logic [3:0] n;
    n = c;
    for (int j = 0; j < 16; j++)
    begin
      n = n + 4'h1;
      if (display_programmed_in[n])
        return n;
    end
    return c;
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    for (int i = 0; i < 12; i++)
    begin
      btn_mode_in[i] = fpb_pkg::BTN_DISABLED;
      release_stretch_time_in[i] = 16'h0000;
    end
    for (int i = 0; i < 16; i++)
      flex_state_in[16 * i +: 16] = {8'hA5, 4'(i), 4'(15 - i)};
    btn_mode_in[1] = fpb_pkg::BTN_SELF_RESET;
    btn_mode_in[2] = fpb_pkg::BTN_LATCHED;
    release_stretch_time_in[1] = 16'h0005;
    tick(8);
    reset_in = 1'b0;
    tick(4);
    for (int i = 0; i < 16; i++)
      rd(16'h0900 + 16'(i), {8'hA5, 4'(i), 4'(15 - i)}, 1'b0);
    rd(16'h0910, 16'h0000, 1'b1);
    rd(16'h08FF, 16'h0000, 1'b1);
    press(5'h00, 30);
    check(16'(nev), 16'h0001);
    check(16'(evk), 16'h0000);
    tick(500);
    check(16'(control_key_active_out[0]), 16'h0001);
    tick(600);
    check(16'(control_key_active_out[0]), 16'h0000);
    press(5'h02, 30);
    check(16'(nev), 16'h0000);
    check(16'(control_key_active_out[2]), 16'h0001);
    press(5'h04, 30);
    check(16'(control_key_active_out[4]), 16'h0000);
    option_fitted_in = 1'b1;
    press(5'h04, 30);
    check(16'(control_key_active_out[4]), 16'h0001);
    tick(1100);
    breaker_keys_in = 1'b1;
    press(5'h01, 30);
    check({15'h0000, br}, 16'h0001);
    check(16'(control_key_active_out[1]), 16'h0000);
    breaker_keys_in = 1'b0;
    check(16'(button_on_out[2]), 16'h0001);
    press(5'h07, 30);
    check(16'({button_on_out[0], button_off_out[0]}), 16'h0000);
    press(5'h08, 30);
    check(16'({button_on_out[1], button_off_out[1]}), 16'h0002);
    tick(100);
    check(16'({button_on_out[1], button_off_out[1]}), 16'h0001);
    check(16'(msg_out), 16'h0002);
    press(5'h09, 30);
    check(16'({button_on_out[2], button_off_out[2], nv_state_out[2]}), 16'h0002);
    check(16'(msg_out), 16'h0025);
    press(5'h09, 30);
    check(16'({button_on_out[2], button_off_out[2], nv_state_out[2]}), 16'h0005);
    check(16'(msg_out), 16'h0024);
    step(1000);
    check(16'(disp_out.active), 16'h0000);
    step(3000);
    check(16'(disp_out.active), 16'h0001);
    check(16'(display_programmed_in[disp_out.idx]), 16'h0001);
    i0 = disp_out.idx;
    step(3000);
    check(16'(disp_out.idx), 16'(nxt(i0)));
    press(5'h13, 30);
    check(16'(disp_out.idx), 16'(nxt(nxt(i0))));
    press(5'h14, 30);
    check(16'(disp_out.active), 16'h0000);
    step(3000);
    check(16'(disp_out.idx), 16'(nxt(nxt(i0))));
    msg_timeout_ms_in = 16'h0014;
    tick(20);
    check(16'(disp_out.cycling), 16'h0001);
    tick(40100);
    check(16'(disp_out.idx), 16'(nxt(nxt(nxt(i0)))));
    msg_timeout_ms_in = 16'h0064;
    step(3000);
    check(16'({disp_out.cycling, disp_out.idx}), 16'(nxt(nxt(nxt(i0)))));
    report_and_stop();
  end
endmodule
`default_nettype wire
